// ==== bench/sdrcpi_ctrl_model.sv ====
// controller-side model that drives the sdram pins one cycle at a time
`timescale 1ns/1ps
module sdrcpi_ctrl_model (
  input  wire logic        clock_i,    // system clock
  output logic             clk_gate_o, // clock gate, high runs
  output logic      [3:0]  cmd_o,      // {cs_n, ras_n, cas_n, we_n}
  output logic      [1:0]  bank_o,     // bank select
  output logic      [10:0] addr_o,     // address
  output logic      [3:0]  mask_o,     // byte masks, high masks
  output logic      [31:0] dq_o,       // write data
  output logic             dq_oe_o     // write data enable
);
  // ----------------------------------------------------------------
  // random source
  // ----------------------------------------------------------------
  logic [15:0] lfsr_r = 16'h376c; // shift register state, fixed seed

  // two galois steps give one 32-bit word
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < 2; i++) begin
      lfsr_r = {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? 16'hb400 : 16'h0000);
      v      = {v[15:0], lfsr_r};
    end
    return v;
  endfunction : rnd

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // gate stays high unless a power test drops it
  initial begin
    clk_gate_o = 1'b1;
    cmd_o      = 4'hf;
    bank_o     = 2'h0;
    addr_o     = 11'h000;
    mask_o     = 4'h0;
    dq_o       = 32'h0000_0000;
    dq_oe_o    = 1'b0;
  end

  // one command slot: pins change only after the falling edge
  task automatic drive(input logic [3:0] cmd, input logic [1:0] bank, input logic [10:0] addr,
                       input logic [3:0] mask, input logic [31:0] data, input logic oe);
    @(negedge clock_i);
    cmd_o   = cmd;
    bank_o  = bank;
    addr_o  = addr;
    mask_o  = mask;
    dq_o    = data;
    dq_oe_o = oe;
  endtask : drive

  // idle slot: deselected with noise on strobes, bank, address and data, masks kept, data enable low
  task automatic idle();
    logic [31:0] r;
    r = rnd();
    drive({1'b1, r[2:0]}, r[4:3], r[15:5], mask_o, rnd(), 1'b0);
  endtask : idle

  // clock gate level, changed in the current falling-edge slot
  task automatic gate(input logic v);
    clk_gate_o = v;
  endtask : gate
endmodule : sdrcpi_ctrl_model

// ==== bench/sdrcpi_tb.sv ====
// self-checking testbench of the sdram pin interface
`timescale 1ns/1ps
`include "sdrcpi_regs.svh"
module sdrcpi_tb;
  // ----------------------------------------------------------------
  // clock, reset and pins
  // ----------------------------------------------------------------
  logic        clock_i = 1'b0; // 40 MHz system clock
  logic        nrst_i  = 1'b0; // sync reset, low
  logic        gate;           // clock gate
  logic [3:0]  cmd;            // {cs_n, ras_n, cas_n, we_n}
  logic [1:0]  bank;           // bank select
  logic [10:0] addr;           // address
  logic [3:0]  mask;           // byte masks
  logic [31:0] c_dq;           // controller data
  logic        c_oe;           // controller drives data
  logic [31:0] d_dq;           // device data
  logic [3:0]  d_oe;           // device lane enables
  logic [31:0] dq_bus;         // resolved data wire
  logic [10:0] mode;           // mode configuration
  logic [3:0]  rows;           // open-row flags
  logic        lowp;           // low power flag
  logic [35:0] exp_q [$];      // expected read beats {oe, data}
  logic [31:0] mem [int];      // expected array contents
  int          err_total   = 0; // mismatches
  int          comparisons = 0; // comparisons made
  int          cyc         = 0; // elapsed cycles
  int          bl          = 1; // burst length in beats

  always #12.5 clock_i = ~clock_i;

  // each lane shows the device while it drives, else the controller
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      dq_bus[8*l+:8] = d_oe[l] ? d_dq[8*l+:8] : c_dq[8*l+:8];
    end
  end

  sdrcpi_ctrl_model ctl (.clock_i(clock_i), .clk_gate_o(gate), .cmd_o(cmd), .bank_o(bank),
    .addr_o(addr), .mask_o(mask), .dq_o(c_dq), .dq_oe_o(c_oe));

  sdrcpi_core dut (.clock_i(clock_i), .nrst_i(nrst_i),
    .clk_gate_i(gate), .cs_n_i(cmd[3]), .ras_n_i(cmd[2]), .cas_n_i(cmd[1]), .we_n_i(cmd[0]),
    .bank_i(bank), .addr_i(addr), .byte_mask_i(mask), .dq_i(dq_bus), .dq_o(d_dq),
    .dq_oe_o(d_oe), .mode_o(mode), .row_open_o(rows), .low_power_o(lowp));

  // ----------------------------------------------------------------
  // comparison and reporting
  // ----------------------------------------------------------------
  task automatic cmp_stat(input string what, input logic [10:0] exp, input logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_stat

  // only lanes expected to drive carry meaningful data
  task automatic cmp_beat(input logic [35:0] e, input logic [3:0] oe, input logic [31:0] d);
    logic [31:0] lm;
    lm = {{8{e[35]}}, {8{e[34]}}, {8{e[33]}}, {8{e[32]}}};
    comparisons++;
    if ({oe, d & lm} !== {e[35:32], e[31:0] & lm}) begin
      err_total++;
      $display("[ERR] read beat expected %h seen %h", e, {oe, d});
    end
  endtask : cmp_beat

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  // watcher: every driven beat takes the oldest note off the queue
  always @(negedge clock_i) begin
    if (nrst_i && d_oe !== 4'h0) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("[ERR] read beat expected none seen %h", {d_oe, d_dq});
      end else begin
        cmp_beat(exp_q.pop_front(), d_oe, d_dq);
      end
    end
  end

  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      $display("[ERR] timeout expected end seen cycle %0d", cyc);
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // command helpers
  // ----------------------------------------------------------------
  task automatic settle();
    repeat (8) ctl.idle();
  endtask : settle

  task automatic done(input string name);
    $display("test %s finished, mismatches %0d", name, err_total);
  endtask : done

  // mode load; ok says whether the device should take it
  task automatic mload(input logic [2:0] code, input logic ok, input logic [10:0] exp);
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_MODE, 2'h0, 11'h020 | code, 4'h0, ctl.rnd(), 1'b0);
    settle();
    cmp_stat("mode", exp, mode);
    if (ok) bl = 1 << code;
  endtask : mload

  task automatic act(input logic [1:0] b, input logic [10:0] row);
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_ACT, b, row, mask, ctl.rnd(), 1'b0);
    ctl.idle();
  endtask : act

  task automatic pre(input logic [1:0] b, input logic all);
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_PRE, b, 11'(all) << `SDRCPI_PRE_ALL_BIT, mask,
              ctl.rnd(), 1'b0);
    settle();
  endtask : pre

  // write burst; later beats go out deselected with noisy strobes
  task automatic wr(input logic [1:0] b, input logic [7:0] col, input logic masked);
    logic [31:0] d;
    logic [31:0] old;
    logic [3:0]  m;
    int          key;
    for (int k = 0; k < bl; k++) begin
      d   = ctl.rnd();
      m   = masked ? d[7:4] : 4'h0;
      key = {b, 8'(col + k)};
      old = mem.exists(key) ? mem[key] : d;
      for (int l = 0; l < 4; l++) begin
        if (!m[l]) old[8*l+:8] = d[8*l+:8];
      end
      mem[key] = old;
      if (k == 0) ctl.drive(sdrcpi_pkg::SDRCPI_CMD_WR, b, {3'h0, col}, m, d, 1'b1);
      else ctl.drive({1'b1, d[10:8]}, ~b, d[26:16], m, d, 1'b1);
    end
    ctl.idle();
  endtask : wr

  // read burst with masks held steady across the whole burst
  task automatic rd(input logic [1:0] b, input logic [7:0] col, input logic ap,
                    input logic [3:0] rm);
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_RD, b, (11'(ap) << `SDRCPI_AUTO_PRE_BIT) | col, rm,
              ctl.rnd(), 1'b0);
    for (int k = 0; k < bl; k++) exp_q.push_back({~rm, mem[{b, 8'(col + k)}]});
    repeat (bl + 8) ctl.idle();
    ctl.drive(4'hf, 2'h0, 11'h000, 4'h0, ctl.rnd(), 1'b0);
  endtask : rd

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(negedge clock_i);
    cmp_stat("reset state", 11'h000, {d_oe, rows, 2'b00, lowp});
    nrst_i = 1'b1;
    // commands ignored while deselected
    ctl.drive(4'h8 | sdrcpi_pkg::SDRCPI_CMD_ACT, 2'h0, 11'h001, 4'h0, ctl.rnd(), 1'b0);
    ctl.drive(4'h8 | sdrcpi_pkg::SDRCPI_CMD_MODE, 2'h0, 11'h023, 4'h0, ctl.rnd(), 1'b0);
    settle();
    cmp_stat("rows", 11'h000, {7'h00, rows});
    cmp_stat("mode", 11'h000, mode);
    done("deselect");
    // burst length codes 0 to 3, one bank each
    for (int c = 0; c < 4; c++) begin
      pre(2'h0, 1'b1);
      mload(3'(c), 1'b1, 11'h020 | 11'(c));
      act(2'(c), 11'(c));
      settle();
      cmp_stat("rows", 11'(1 << c), {7'h00, rows});
      wr(2'(c), 8'(16 * c), 1'b0);
      rd(2'(c), 8'(16 * c), 1'b0, 4'h0);
    end
    done("burst lengths");
    mload(3'h2, 1'b0, 11'h023); // REFUSED mode load with rows open
    pre(2'h0, 1'b1);
    cmp_stat("rows", 11'h000, {7'h00, rows});
    mload(3'h2, 1'b1, 11'h022);
    done("precharge all");
    // bank select, masked writes and read masks
    act(2'h0, 11'h401);
    act(2'h1, 11'h401);
    wr(2'h0, 8'h40, 1'b0);
    wr(2'h1, 8'h40, 1'b0);
    wr(2'h0, 8'h40, 1'b1);
    rd(2'h0, 8'h40, 1'b0, 4'h0);
    rd(2'h1, 8'h40, 1'b0, 4'h5);
    done("masks");
    pre(2'h1, 1'b0);
    cmp_stat("rows", 11'h001, {7'h00, rows});
    rd(2'h0, 8'h40, 1'b1, 4'h8);
    settle();
    cmp_stat("rows", 11'h000, {7'h00, rows});
    done("auto precharge");
    // precharge power-down; inputs ignored meanwhile
    ctl.gate(1'b0);
    settle();
    cmp_stat("low power", 11'h001, {10'h000, lowp});
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_ACT, 2'h2, 11'h002, 4'h0, ctl.rnd(), 1'b0);
    settle();
    ctl.gate(1'b1);
    settle();
    cmp_stat("low power", 11'h000, {10'h000, lowp});
    cmp_stat("rows", 11'h000, {7'h00, rows});
    // self refresh entered with the refresh command
    ctl.drive(sdrcpi_pkg::SDRCPI_CMD_REF, 2'h0, 11'h000, 4'h0, ctl.rnd(), 1'b0);
    ctl.gate(1'b0);
    settle();
    cmp_stat("low power", 11'h001, {10'h000, lowp});
    ctl.gate(1'b1);
    settle();
    cmp_stat("low power", 11'h000, {10'h000, lowp});
    // active power-down keeps the row open
    act(2'h3, 11'h003);
    ctl.gate(1'b0);
    settle();
    cmp_stat("low power", 11'h001, {10'h000, lowp});
    ctl.gate(1'b1);
    settle();
    cmp_stat("rows", 11'h008, {7'h00, rows});
    cmp_stat("beats left", 11'h000, 11'(exp_q.size()));
    done("power");
    end_of_test();
  end
endmodule : sdrcpi_tb

// ==== src/sdrcpi_core.sv ====
// sdram command and data pin interface with a small behavioural array
`timescale 1ns/1ps
`include "sdrcpi_regs.svh"
// Notes on behaviour
// RULE1 - inputs sampled only on rising clock edge
// RULE2 - each edge advances burst counter, output registers
// RULE3 - clock gate low stops internal clock
// RULE4 - clock gate asynchronous inside power-down states
// RULE5 - inputs ignored in power-down and self refresh
// RULE6 - controller may tie clock gate high
// RULE7 - commands taken only with chip select low
// RULE8 - bursts and masks continue while deselected
// RULE9 - command from strobes plus chip select
// RULE10 - masked write lanes are not stored
// RULE11 - read mask floats lane two clocks later
// RULE12 - mask bit n covers byte lane n
// RULE13 - bank select picks the target bank
// RULE14 - row from all address, column from low
// RULE15 - precharge flag bit selects auto precharge
// RULE16 - precharge flag high closes all banks
// RULE17 - mode load takes address as opcode
// RULE18 - one shared bidirectional data bus
// RULE19 - activate opens row before column access
// RULE20 - burst length 1,2,4,8 or page, terminate
// RULE21 - controller issues no-op when idle
module sdrcpi_core #(
  parameter int ROWS_SIM = 4,  // rows kept per bank in the array model
  parameter int COLS     = 256 // columns per row
) (
  input  wire logic        clock_i,     // system clock
  input  wire logic        nrst_i,      // sync reset, low
  input  wire logic        clk_gate_i,  // clock gate, high runs
  input  wire logic        cs_n_i,      // chip select, low
  input  wire logic        ras_n_i,     // row strobe, low
  input  wire logic        cas_n_i,     // column strobe, low
  input  wire logic        we_n_i,      // write strobe, low
  input  wire logic [1:0]  bank_i,      // bank select
  input  wire logic [10:0] addr_i,      // address
  input  wire logic [3:0]  byte_mask_i, // byte masks
  input  wire logic [31:0] dq_i,        // data bus in
  output logic      [31:0] dq_o,        // data bus out
  output logic      [3:0]  dq_oe_o,     // lane output enables
  output logic      [10:0] mode_o,      // mode configuration
  output logic      [3:0]  row_open_o,  // open-row flags per bank
  output logic             low_power_o  // power-down or self refresh
);
  localparam int RW = $clog2(ROWS_SIM);
  localparam int LAT = `SDRCPI_CAS_LAT;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [31:0]             mem [4][ROWS_SIM][COLS]; // array model
  sdrcpi_pkg::sdrcpi_pwr_t pwr_r;        // power state
  logic                    gate_sync;    // gate after two flops
  logic                    gate_r;       // gate registered synchronously
  logic                    run;          // internal clock active
  logic                    cs_n_r;       // registered inputs
  logic                    ras_n_r;
  logic                    cas_n_r;
  logic                    we_n_r;
  logic [1:0]              bank_r;
  logic [10:0]             addr_r;
  logic [3:0]              mask_r;
  logic [31:0]             din_r;
  logic [10:0]             row_r [4];    // open row per bank
  logic [3:0]              open_r;       // open-row flags
  logic                    bst_rd_r;     // read burst active
  logic                    bst_wr_r;     // write burst active
  logic                    bst_ap_r;     // auto precharge pending
  logic [1:0]              bst_bank_r;   // burst bank
  logic [7:0]              bst_col_r;    // burst column counter
  logic [8:0]              bst_left_r;   // beats left
  logic [LAT-1:0]          rd_pipe_r;    // read valid pipeline
  logic [31:0]             rd_data_r [LAT]; // read data pipeline
  logic [3:0]              mask_d1_r;    // mask delay, stage 1
  sdrcpi_pkg::sdrcpi_cmd_t cmd;          // decoded command
  logic [8:0]              bl;           // programmed burst length

  // decode burst length code of the mode configuration
  function automatic logic [8:0] bl_dec(input logic [2:0] code);
    unique case (code)
      3'h0:    bl_dec = 9'h001;
      3'h1:    bl_dec = 9'h002;
      3'h2:    bl_dec = 9'h004;
      3'h3:    bl_dec = 9'h008;
      default: bl_dec = `SDRCPI_FULL_PAGE_LEN;
    endcase
  endfunction : bl_dec

  // map a row address to the model's row index
  function automatic logic [RW-1:0] row_ix(input logic [10:0] row);
    row_ix = row[RW-1:0];
  endfunction : row_ix

  // ---------------------------------------------------------------
  // clock gating and power state
  // ---------------------------------------------------------------
  sdrcpi_sync u_gate_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     (clk_gate_i),
    .q_o     (gate_sync)
  );

  // synchronous sampling of the gate in normal operation
  always_ff @(posedge clock_i) begin
    if (!nrst_i) gate_r <= 1'b1;
    else         gate_r <= clk_gate_i; // RULE4
  end

  // internal clock runs only in run state with gate high
  assign run = (pwr_r == sdrcpi_pkg::SDRCPI_RUN) && gate_r; // RULE3 RULE6

  // power state transitions
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pwr_r <= sdrcpi_pkg::SDRCPI_RUN;
    end else begin
      unique case (pwr_r)
        sdrcpi_pkg::SDRCPI_RUN: begin
          if (!gate_r) begin // RULE3
            if (bst_rd_r || bst_wr_r) pwr_r <= sdrcpi_pkg::SDRCPI_HOLD;
            else if (open_r != 4'h0)  pwr_r <= sdrcpi_pkg::SDRCPI_ACT_PD;
            // registered strobes: cmd already reads no-op once the gate is low
            else if ({cs_n_r, ras_n_r, cas_n_r, we_n_r} == sdrcpi_pkg::SDRCPI_CMD_REF)
              pwr_r <= sdrcpi_pkg::SDRCPI_SELF_REF;
            else pwr_r <= sdrcpi_pkg::SDRCPI_PRE_PD;
          end
        end
        sdrcpi_pkg::SDRCPI_HOLD: begin
          if (gate_r) pwr_r <= sdrcpi_pkg::SDRCPI_RUN; // synchronous exit
        end
        default: begin
          // power-down and self refresh: gate seen asynchronously
          if (gate_sync) pwr_r <= sdrcpi_pkg::SDRCPI_RUN; // RULE4
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input registers
  // ---------------------------------------------------------------
  // pins are registered on the rising edge in run state, gate low included; in other states cs_n_r is forced high, the rest held
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      cs_n_r  <= 1'b1;
      ras_n_r <= 1'b1;
      cas_n_r <= 1'b1;
      we_n_r  <= 1'b1;
      bank_r  <= 2'h0;
      addr_r  <= 11'h000;
      mask_r  <= 4'h0;
      din_r   <= 32'h0000_0000;
    end else if (run || (pwr_r == sdrcpi_pkg::SDRCPI_RUN)) begin // RULE1 RULE5
      cs_n_r  <= cs_n_i;
      ras_n_r <= ras_n_i;
      cas_n_r <= cas_n_i;
      we_n_r  <= we_n_i;
      bank_r  <= bank_i;
      addr_r  <= addr_i;
      mask_r  <= byte_mask_i;
      din_r   <= dq_i;
    end else begin
      cs_n_r  <= 1'b1; // inputs disabled in low power
    end
  end

  // command code formed from chip select and the three strobes
  always_comb begin
    cmd = sdrcpi_pkg::sdrcpi_cmd_t'({1'b0, ras_n_r, cas_n_r, we_n_r}); // RULE9
    if (cs_n_r || !run) cmd = sdrcpi_pkg::SDRCPI_CMD_NOP; // RULE7
  end

  assign bl = bl_dec(mode_o[`SDRCPI_BL_MSB:`SDRCPI_BL_LSB]); // RULE20

  // ---------------------------------------------------------------
  // mode configuration and bank rows
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) mode_o <= `SDRCPI_MODE_RST;
    else if (cmd == sdrcpi_pkg::SDRCPI_CMD_MODE && open_r == 4'h0)
      mode_o <= addr_r; // RULE17
  end

  // open and close rows per bank
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      open_r <= 4'h0;
      for (int b = 0; b < 4; b++) row_r[b] <= 11'h000;
    end else begin
      // auto precharge first, so an activate on the same edge wins
      if (run && (bst_rd_r || bst_wr_r) && bst_ap_r && bst_left_r == 9'h001)
        open_r[bst_bank_r] <= 1'b0; // RULE15
      if (cmd == sdrcpi_pkg::SDRCPI_CMD_ACT) begin
        open_r[bank_r] <= 1'b1;    // RULE13 RULE19
        row_r[bank_r]  <= addr_r;  // RULE14
      end else if (cmd == sdrcpi_pkg::SDRCPI_CMD_PRE) begin
        if (addr_r[`SDRCPI_PRE_ALL_BIT]) open_r <= 4'h0; // RULE16
        else open_r[bank_r] <= 1'b0; // RULE16
      end
    end
  end

  // ---------------------------------------------------------------
  // burst engine
  // ---------------------------------------------------------------
  // new access needs an open row in its bank; continues when deselected
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      bst_rd_r   <= 1'b0;
      bst_wr_r   <= 1'b0;
      bst_ap_r   <= 1'b0;
      bst_bank_r <= 2'h0;
      bst_col_r  <= 8'h00;
      bst_left_r <= 9'h000;
    end else if (run) begin // RULE3
      if ((cmd == sdrcpi_pkg::SDRCPI_CMD_RD || cmd == sdrcpi_pkg::SDRCPI_CMD_WR)
          && open_r[bank_r]) begin // RULE19
        bst_rd_r   <= (cmd == sdrcpi_pkg::SDRCPI_CMD_RD);
        bst_wr_r   <= (cmd == sdrcpi_pkg::SDRCPI_CMD_WR);
        bst_ap_r   <= addr_r[`SDRCPI_AUTO_PRE_BIT]; // RULE15
        bst_bank_r <= bank_r; // RULE13
        bst_col_r  <= addr_r[`SDRCPI_COL_MSB:0]; // RULE14
        bst_left_r <= bl;
      end else if (cmd == sdrcpi_pkg::SDRCPI_CMD_BST ||
                   cmd == sdrcpi_pkg::SDRCPI_CMD_PRE) begin
        bst_rd_r <= 1'b0; // RULE20
        bst_wr_r <= 1'b0;
      end else if (bst_rd_r || bst_wr_r) begin // RULE8
        bst_col_r  <= bst_col_r + 8'h01; // RULE2
        bst_left_r <= bst_left_r - 9'h001;
        if (bst_left_r == 9'h001) begin
          bst_rd_r <= 1'b0;
          bst_wr_r <= 1'b0;
        end
      end
    end
  end

  // write beats: first beat comes with the command, masked lanes kept
  logic       wr_beat;    // a write beat lands this edge
  logic [1:0] wr_bank;    // its bank
  logic [7:0] wr_col;     // its column
  always_comb begin
    wr_beat = 1'b0;
    wr_bank = bst_bank_r;
    wr_col  = bst_col_r;
    if (run && cmd == sdrcpi_pkg::SDRCPI_CMD_WR && open_r[bank_r]) begin
      wr_beat = 1'b1;
      wr_bank = bank_r;
      wr_col  = addr_r[`SDRCPI_COL_MSB:0];
    end else if (run && bst_wr_r && bst_left_r > 9'h001 &&
                 cmd != sdrcpi_pkg::SDRCPI_CMD_BST &&
                 cmd != sdrcpi_pkg::SDRCPI_CMD_PRE) begin
      wr_beat = 1'b1;
      wr_col  = bst_col_r + 8'h01;
    end
  end

  // store unmasked lanes into the open row; one process owns the array
  always_ff @(posedge clock_i) begin
    for (int g = 0; g < 4; g++) begin
      if (wr_beat && !mask_r[g]) // RULE10 RULE12
        mem[wr_bank][row_ix(row_r[wr_bank])][wr_col][8*g +: 8] <= din_r[8*g +: 8];
    end
  end

  // ---------------------------------------------------------------
  // read pipeline and output drivers
  // ---------------------------------------------------------------
  logic       rd_beat;  // a read beat is fetched this edge
  logic [1:0] rd_bank;  // its bank
  logic [7:0] rd_col;   // its column
  always_comb begin
    rd_beat = 1'b0;
    rd_bank = bst_bank_r;
    rd_col  = bst_col_r;
    if (cmd == sdrcpi_pkg::SDRCPI_CMD_RD && open_r[bank_r]) begin
      rd_beat = 1'b1;
      rd_bank = bank_r;
      rd_col  = addr_r[`SDRCPI_COL_MSB:0];
    end else if (run && bst_rd_r && bst_left_r > 9'h001 &&
                 cmd != sdrcpi_pkg::SDRCPI_CMD_BST &&
                 cmd != sdrcpi_pkg::SDRCPI_CMD_PRE) begin
      rd_beat = 1'b1;
      rd_col  = bst_col_r + 8'h01;
    end
  end

  // read latency pipeline, advanced each running edge
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rd_pipe_r <= '0;
      for (int i = 0; i < LAT; i++) rd_data_r[i] <= 32'h0000_0000;
    end else if (run) begin // RULE2
      rd_pipe_r    <= {rd_pipe_r[LAT-2:0], rd_beat};
      rd_data_r[0] <= mem[rd_bank][row_ix(row_r[rd_bank])][rd_col];
      for (int i = 1; i < LAT; i++) rd_data_r[i] <= rd_data_r[i-1];
    end
  end

  // one mask stage plus the output register give the two-clock float
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mask_d1_r <= 4'h0;
    end else if (run) begin
      mask_d1_r <= mask_r;    // RULE11 RULE8
    end
  end

  // output registers drive the shared bus, lane by lane
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      dq_o    <= 32'h0000_0000;
      dq_oe_o <= 4'h0;
    end else if (run) begin // RULE2
      dq_o <= rd_data_r[LAT-1]; // RULE18
      for (int l = 0; l < 4; l++)
        dq_oe_o[l] <= rd_pipe_r[LAT-1] && !mask_d1_r[l]; // RULE11 RULE12
    end else if (pwr_r != sdrcpi_pkg::SDRCPI_RUN &&
                 pwr_r != sdrcpi_pkg::SDRCPI_HOLD) begin
      dq_oe_o <= 4'h0; // drivers off in low power
    end
  end

  // status outputs
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      row_open_o  <= 4'h0;
      low_power_o <= 1'b0;
    end else begin
      row_open_o  <= open_r;
      low_power_o <= (pwr_r != sdrcpi_pkg::SDRCPI_RUN) &&
                     (pwr_r != sdrcpi_pkg::SDRCPI_HOLD); // RULE5
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_desel_no_open;
    @(posedge clock_i) disable iff (!nrst_i)
    (cs_n_r && open_r == 4'h0) |=> (open_r == 4'h0);
  endproperty
  a_desel_no_open: assert property (p_desel_no_open) // RULE7
    else $error("row opened while deselected");

  property p_pre_all;
    @(posedge clock_i) disable iff (!nrst_i)
    (cmd == sdrcpi_pkg::SDRCPI_CMD_PRE && addr_r[10]) |=> (open_r == 4'h0);
  endproperty
  a_pre_all: assert property (p_pre_all) // RULE16
    else $error("precharge all left a row open");

  property p_act_opens;
    @(posedge clock_i) disable iff (!nrst_i)
    (cmd == sdrcpi_pkg::SDRCPI_CMD_ACT) |=> open_r[$past(bank_r)];
  endproperty
  a_act_opens: assert property (p_act_opens) // RULE13
    else $error("activate did not open bank");

  property p_mask_float;
    @(posedge clock_i) disable iff (!nrst_i)
    (run && mask_d1_r[0]) |=> !dq_oe_o[0];
  endproperty
  a_mask_float: assert property (p_mask_float) // RULE11
    else $error("masked read lane driven");

  property p_mode_load;
    @(posedge clock_i) disable iff (!nrst_i)
    (cmd == sdrcpi_pkg::SDRCPI_CMD_MODE && open_r == 4'h0) |=> (mode_o == $past(addr_r));
  endproperty
  a_mode_load: assert property (p_mode_load) // RULE17
    else $error("mode not loaded from address");

  property p_hold_freeze;
    @(posedge clock_i) disable iff (!nrst_i)
    (pwr_r == sdrcpi_pkg::SDRCPI_HOLD) |=> $stable(bst_col_r);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) // RULE3
    else $error("burst moved while clock held");

  property p_burst_advance;
    @(posedge clock_i) disable iff (!nrst_i)
    (run && bst_rd_r && bst_left_r > 9'h001 && cmd == sdrcpi_pkg::SDRCPI_CMD_NOP)
      |=> (bst_col_r == $past(bst_col_r) + 8'h01);
  endproperty
  a_burst_advance: assert property (p_burst_advance) // RULE2
    else $error("burst counter did not advance");

  property p_lowpower_off;
    @(posedge clock_i) disable iff (!nrst_i)
    low_power_o |-> (dq_oe_o == 4'h0);
  endproperty
  a_lowpower_off: assert property (p_lowpower_off) // RULE5
    else $error("drivers on in low power");
endmodule : sdrcpi_core

// ==== src/sdrcpi_pkg.sv ====
// types shared by the sdram pin interface
package sdrcpi_pkg;
  // command code {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    SDRCPI_CMD_MODE  = 4'h0,
    SDRCPI_CMD_REF   = 4'h1,
    SDRCPI_CMD_PRE   = 4'h2,
    SDRCPI_CMD_ACT   = 4'h3,
    SDRCPI_CMD_WR    = 4'h4,
    SDRCPI_CMD_RD    = 4'h5,
    SDRCPI_CMD_BST   = 4'h6,
    SDRCPI_CMD_NOP   = 4'h7
  } sdrcpi_cmd_t;
  // power state of the internal clock
  typedef enum logic [2:0] {
    SDRCPI_RUN,
    SDRCPI_PRE_PD,
    SDRCPI_ACT_PD,
    SDRCPI_SELF_REF,
    SDRCPI_HOLD
  } sdrcpi_pwr_t;
endpackage : sdrcpi_pkg

// ==== src/sdrcpi_regs.svh ====
// timing counts, field positions and reset values of the sdram pin interface
`ifndef SDRCPI_REGS_SVH
`define SDRCPI_REGS_SVH
`define SDRCPI_PRE_ALL_BIT   10
`define SDRCPI_AUTO_PRE_BIT  10
`define SDRCPI_COL_MSB       7
`define SDRCPI_MASK_LAT      2
`define SDRCPI_CAS_LAT       2
`define SDRCPI_MODE_RST      11'h000
`define SDRCPI_BL_LSB        0
`define SDRCPI_BL_MSB        2
`define SDRCPI_FULL_PAGE_LEN 9'h100
`endif

// ==== src/sdrcpi_sync.sv ====
// two-flop synchroniser for the asynchronous clock-gate level
`timescale 1ns/1ps
module sdrcpi_sync (
  input  wire logic clock_i, // clock
  input  wire logic nrst_i,  // sync reset, low
  input  wire logic d_i,     // async level
  output logic      q_o      // synchronised level
);
  logic meta_r; // first stage, read only by q_o
  // ---------------------------------------------------------------
  // two stages
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      meta_r <= 1'b0;
      q_o    <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule : sdrcpi_sync
